// [bench/apb_host.sv]
// Host model: APB master standing for the polling gateway.
// Assumes each call starts just after a rising clock edge.
`default_nettype none
module apb_host (
    // Clock
    input wire logic clk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Ends an edge after release, so no signal is driven twice at once
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
endmodule // apb_host
`default_nettype wire

// [bench/drive_status_monitor_words_tb_top.sv]
// Bench: random drive states polled over APB, units and interrupts.
// Assumes apb_host as bus master and dsm_chk bound to the bank.
`default_nettype none
module drive_status_monitor_words_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CODE = 8'h3C; // Arbitrary typeform code
    logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, e, t;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v, p, pn, seed, q;
    logic [7:0] strap;
    logic [3:0] msk, ev;
    int num_errors = 0;
    int n_tests = 0;
    logic [11:0] adr [8] = '{12'h034, 12'h038, 12'h03C, 12'h020, 12'h030,
        12'h070, 12'h078, 12'h08C};
    // Drive-internal bits are masked off
    logic [31:0] mk [8] = '{32'hFFFFFFFF, 32'hFFFF9BFF, 32'hFFFF1F8F,
        32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFF1FFF};
    logic [31:0] ex [8];
    apb_host h (.*);
    drive_status_monitor_words #(.MODEL_CODE(CODE)) dut (.*,
        .run_ahead_input(v[0]), .back_spin_input(v[1]),
        .multi_input_low(v[7:2]), .multi_input_7(v[8]),
        .fault_clear_input(v[9]), .drive_gate_input(v[10]),
        .rated_kw_strap(strap), .blower_state(v[11]),
        .fault_contact(v[12]), .main_contactor(v[13]),
        .option_contact(v[14]), .speed_reached_contact(v[15]),
        .speed_floor_contact(v[16]), .accelerating(v[17]),
        .decelerating(v[18]), .retrying(v[19]), .running_or_braking(v[20]),
        .tripped(v[21]), .running(v[22]), .forward(v[23]),
        .ramp_set_two(v[24]), .jog_mode(v[25]), .feedback_active(v[26]),
        .dc_braking(v[27]), .vf_set_two(v[28]), .coasting(v[29]),
        .emergency_off(v[30]), .command_mode(p[17:16]),
        .frequency_mode(p[19:18]), .out_voltage_pct(p[15:0]),
        .in_voltage_pct(p[31:16]), .in_power_centi_kw({6'h00, p[17:0]}),
        .out_power_centi_kw({{6{p[17]}}, p[17:0]}));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] pwx(int c, bit u, bit s);
        int n;
        n = u ? c / 10 : c;
        if (n > (s ? 32767 : 65535)) n = s ? 32767 : 65535;
        if (n < (s ? -32768 : 0)) n = s ? -32768 : 0;
        return {16'h0000, n[15:0]};
    endfunction
    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        p = '0;
        seed = 32'h0000863F;
        // Straps either side of the tenth-unit threshold, a reset apart
        for (int r = 0; r < 2; r++) begin
            rst <= 1'b1;
            v <= '0;
            strap <= 8'h4A + 8'(r);
            repeat (5) @(posedge clk);
            rst <= 1'b0;
            ev = '0;
            t = r[0];
            repeat (4) @(posedge clk);
            h.xfer(1'b0, 12'h200, 32'h0, q, e);
            cmp({31'h0, e}, 32'h1);
            cmp(q, 32'h0);
            for (int k = 0; k < 20; k++) begin
                msk = seed[3:0];
                h.xfer(1'b1, 12'h404, {28'h0, msk}, q, e);
                seed = xs(seed);
                pn = (k == 0) ? 32'h00020000 : xs(seed);
                ev |= {seed[30] & ~v[30], seed[22] & ~v[22],
                    seed[9] & ~v[9], seed[21] & ~v[21]};
                v <= seed;
                p <= pn;
                ex = '{{16'h0, seed[10:8], 5'h00, seed[7:0]},
                    {16'h0, seed[21], 2'h0, seed[20:19], 1'b0, seed[18:11],
                    2'h0}, {16'h0, 3'h0, seed[30:25], 3'h0, seed[24:23], 1'b0,
                    seed[22]}, {16'h0, pn[15:0]}, {16'h0, pn[31:16]},
                    pwx(int'(pn[17:0]), t, 1'b0),
                    pwx(int'($signed(pn[17:0])), t, 1'b1),
                    {19'h0, pn[19:16], t, CODE}};
                for (int i = 0; i < 8; i++) begin
                    h.xfer(1'b1, adr[i], xs(pn + i), q, e);
                    cmp({31'h0, e}, 32'h0);
                    h.xfer(1'b0, adr[i], 32'h0, q, e);
                    cmp(q & mk[i], ex[i]);
                end
                h.xfer(1'b0, 12'h404, 32'h0, q, e);
                cmp(q, {28'h0, msk});
                cmp({31'h0, irq}, {31'h0, |(ev & msk)});
                h.xfer(1'b0, 12'h400, 32'h0, q, e);
                cmp(q, {28'h0, ev});
                ev = '0;
                cmp({31'h0, irq}, 32'h0);
            end
        end
        final_report();
    end
endmodule // drive_status_monitor_words_tb_top
`default_nettype wire

// [bench/dsm_chk.sv]
// Checker: APB answer timing and fixed bits of the monitor bank.
// Assumes a bind onto the bank's top module.
`default_nettype none
module dsm_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus and interrupt
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence take_s; psel && penable && !pready; endsequence
    sequence rd_s(a); pready && !pwrite && !pslverr && paddr == a; endsequence
    ans_delay_a: assert property (take_s |=> pready)
        else $error("pready late");
    no_stray_a: assert property (pready |-> $past(psel && penable))
        else $error("pready stray");
    err_data_a: assert property (pslverr |-> pready && (pwrite || !prdata))
        else $error("bad error answer");
    in_zero_a: assert property (
        rd_s(12'h034) |-> prdata[12:8] == 5'h00) else $error("input bits");
    out_zero_a: assert property (
        rd_s(12'h038) |-> prdata[1:0] == 2'h0) else $error("output bits");
    st1_zero_a: assert property (
        rd_s(12'h03C) |-> !prdata[1]) else $error("status bit");
    high_zero_a: assert property (pready && !pwrite && paddr[11:10] == 2'h0
        |-> prdata[31:16] == 16'h0000) else $error("upper half set");
    irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable
        && paddr[11:3] == 9'h080)) else $error("irq fell alone");
endmodule // dsm_chk
bind drive_status_monitor_words dsm_chk u_chk (.*);
`default_nettype wire

// [src/drive_monitor_pkg.sv]
// Package of the drive status monitor bank: register indices, field
// positions, reset values and interrupt event layout.
// Assumes APB byte addresses equal four times a register index.
`default_nettype none
package drive_monitor_pkg;
    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [9:0] IDX_OUT_VOLT = 10'h008;
    localparam logic [9:0] IDX_IN_VOLT = 10'h00C;
    localparam logic [9:0] IDX_INPUT_TERMINAL_STATUS = 10'h00D;
    localparam logic [9:0] IDX_OUTPUT_TERMINAL_AND_STATUS_TWO = 10'h00E;
    localparam logic [9:0] IDX_DRIVE_STATUS_ONE = 10'h00F;
    localparam logic [9:0] IDX_IN_POWER_KW = 10'h01C;
    localparam logic [9:0] IDX_OUT_POWER_KW = 10'h01E;
    localparam logic [9:0] IDX_MODEL_MODE = 10'h023;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h100;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h101;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int IN_RUN_AHEAD_BIT = 0;
    localparam int IN_BACK_SPIN_BIT = 1;
    localparam int IN_MULTI_LOW_BIT = 2;
    localparam int IN_MULTI7_BIT = 13;
    localparam int IN_FAULT_CLEAR_BIT = 14;
    localparam int IN_DRIVE_GATE_BIT = 15;
    localparam int OUT_BLOWER_BIT = 2;
    localparam int OUT_FAULT_BIT = 3;
    localparam int OUT_MAIN_BIT = 4;
    localparam int OUT_OPTION_BIT = 5;
    localparam int OUT_REACHED_BIT = 6;
    localparam int OUT_FLOOR_BIT = 7;
    localparam int ST2_ACCEL_BIT = 8;
    localparam int ST2_DECEL_BIT = 9;
    localparam int ST2_RETRY_BIT = 11;
    localparam int ST2_RUN_BIT = 12;
    localparam int ST2_TRIP_BIT = 15;
    localparam int ST1_RUN_BIT = 0;
    localparam int ST1_FWD_BIT = 2;
    localparam int ST1_ACC2_BIT = 3;
    localparam int ST1_JOG_BIT = 7;
    localparam int ST1_FEEDBACK_BIT = 8;
    localparam int ST1_DC_BRAKE_BIT = 9;
    localparam int ST1_VF2_BIT = 10;
    localparam int ST1_COAST_BIT = 11;
    localparam int ST1_EMERG_BIT = 12;
    localparam int MODEL_CODE_LSB = 0;
    localparam int MODEL_PWR_UNITS_BIT = 8;
    localparam int MODEL_CMD_MODE_LSB = 9;
    localparam int MODEL_FREQ_MODE_LSB = 11;
    // ---------------------------------------------------------------
    // Reset values, limits and interrupt events
    // ---------------------------------------------------------------
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] SIGNED_MAX = 16'h7FFF;
    localparam logic [15:0] SIGNED_MIN = 16'h8000;
    localparam logic [15:0] UNSIGNED_MAX = 16'hFFFF;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
    localparam int EV_TRIP = 0;
    localparam int EV_FAULT_CLEAR = 1;
    localparam int EV_RUN_START = 2;
    localparam int EV_EMERG_OFF = 3;
    localparam logic [1:0] STRAP_WAIT = 2'h3;
endpackage
`default_nettype wire

// [src/drive_status_monitor_words.sv]
// Read-only bank of drive monitor words on an APB slave, with a
// sticky, maskable interrupt on drive events.
// Assumes terminal pins and the capacity strap are asynchronous and
// drive-state inputs come from logic on clk.
//
// The APB interface to the registers was decided locally.
`default_nettype none
module drive_status_monitor_words #(
    // Arbitrary neutral typeform code
    parameter logic [7:0] MODEL_CODE = 8'h5A,
    // Ratings at or above this many kW report in 0.1 kW steps
    parameter logic [7:0] TENTH_KW_RATING = 8'h4B
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Input terminals, high when shorted to common_return
    input wire logic run_ahead_input,
    input wire logic back_spin_input,
    input wire logic [5:0] multi_input_low,
    input wire logic multi_input_7,
    input wire logic fault_clear_input,
    input wire logic drive_gate_input,
    // Rated capacity strap in kW
    input wire logic [7:0] rated_kw_strap,
    // Output terminal states
    input wire logic blower_state,
    input wire logic fault_contact,
    input wire logic main_contactor,
    input wire logic option_contact,
    input wire logic speed_reached_contact,
    input wire logic speed_floor_contact,
    // Drive state
    input wire logic accelerating,
    input wire logic decelerating,
    input wire logic retrying,
    input wire logic running_or_braking,
    input wire logic tripped,
    input wire logic running,
    input wire logic forward,
    input wire logic ramp_set_two,
    input wire logic jog_mode,
    input wire logic feedback_active,
    input wire logic dc_braking,
    input wire logic vf_set_two,
    input wire logic coasting,
    input wire logic emergency_off,
    input wire logic [1:0] command_mode,
    input wire logic [1:0] frequency_mode,
    // Analogue figures
    input wire logic [15:0] out_voltage_pct,
    input wire logic [15:0] in_voltage_pct,
    input wire logic signed [23:0] in_power_centi_kw,
    input wire logic signed [23:0] out_power_centi_kw,
    // Interrupt
    output logic irq
);
    // ---------------------------------------------------------------
    // Types and declarations
    // ---------------------------------------------------------------
    typedef enum logic [0:0] {
        apb_idle,
        apb_answer
    } apb_state_type;

    localparam int PIN_W = 11;

    apb_state_type state_ff;
    apb_state_type nxt_state;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_level;
    logic [7:0] strap_level;
    logic [1:0] strap_cnt_ff;
    logic tenth_units_ff;
    logic [15:0] in_term_ff;
    logic [15:0] out_term_ff;
    logic [15:0] stat_one_ff;
    logic [15:0] model_ff;
    logic [15:0] out_volt_ff;
    logic [15:0] in_volt_ff;
    logic [15:0] in_power_word;
    logic [15:0] out_power_word;
    logic [15:0] nxt_in_term;
    logic [15:0] nxt_out_term;
    logic [15:0] nxt_stat_one;
    logic [15:0] nxt_model;
    logic [IRQ_VEC-1:0] ev_level;
    logic [IRQ_VEC-1:0] ev_prev_ff;
    logic [IRQ_VEC-1:0] ev_pulse;
    logic [IRQ_VEC-1:0] irq_status_ff;
    logic [IRQ_VEC-1:0] irq_mask_ff;
    logic [IRQ_VEC-1:0] nxt_irq_status;
    logic irq_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] read_word;
    logic addr_hit;
    wire access_start;
    wire read_take;
    wire write_take;
    wire [9:0] reg_idx;
    wire hit_in_term;
    wire hit_out_term;
    wire hit_stat_one;
    wire hit_model;
    wire hit_out_volt;
    wire hit_in_volt;
    wire hit_in_power;
    wire hit_out_power;
    wire hit_irq_status;
    wire hit_irq_mask;

    localparam int IRQ_VEC = drive_monitor_pkg::IRQ_W;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    assign pin_raw = {drive_gate_input, fault_clear_input, multi_input_7,
                      multi_input_low, back_spin_input, run_ahead_input};

    pin_sync #(
        .W(PIN_W)
    ) u_term_sync (
        .clk(clk),
        .rst(rst),
        .pin_in(pin_raw),
        .level_out(pin_level)
    );

    pin_sync #(
        .W(8)
    ) u_strap_sync (
        .clk(clk),
        .rst(rst),
        .pin_in(rated_kw_strap),
        .level_out(strap_level)
    );

    // ---------------------------------------------------------------
    // Power units flag from rated capacity
    // ---------------------------------------------------------------
    // Strap is caught once the synchroniser has filled after release;
    // no bus path reaches the flag, so software cannot change it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_cnt_ff <= 2'h0;
        end else if (strap_cnt_ff != drive_monitor_pkg::STRAP_WAIT) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tenth_units_ff <= 1'b0;
        end else if (strap_cnt_ff == 2'h2) begin
            tenth_units_ff <= (strap_level >= TENTH_KW_RATING);
        end
    end

    // ---------------------------------------------------------------
    // Power words
    // ---------------------------------------------------------------
    power_scaler #(
        .SIGNED_WORD(1'b0)
    ) u_in_power (
        .clk(clk),
        .rst(rst),
        .centi_kw(in_power_centi_kw),
        .tenth_units(tenth_units_ff),
        .word_out(in_power_word)
    );

    // Output power may flow back, so it reads as a signed word
    power_scaler #(
        .SIGNED_WORD(1'b1)
    ) u_out_power (
        .clk(clk),
        .rst(rst),
        .centi_kw(out_power_centi_kw),
        .tenth_units(tenth_units_ff),
        .word_out(out_power_word)
    );

    // ---------------------------------------------------------------
    // Monitor word assembly
    // ---------------------------------------------------------------
    always_comb begin
        nxt_in_term = drive_monitor_pkg::WORD_RST;
        nxt_in_term[drive_monitor_pkg::IN_RUN_AHEAD_BIT] = pin_level[0];
        nxt_in_term[drive_monitor_pkg::IN_BACK_SPIN_BIT] = pin_level[1];
        nxt_in_term[drive_monitor_pkg::IN_MULTI_LOW_BIT +: 6] =
            pin_level[7:2];
        nxt_in_term[drive_monitor_pkg::IN_MULTI7_BIT] = pin_level[8];
        nxt_in_term[drive_monitor_pkg::IN_FAULT_CLEAR_BIT] = pin_level[9];
        nxt_in_term[drive_monitor_pkg::IN_DRIVE_GATE_BIT] = pin_level[10];
    end

    always_comb begin
        nxt_out_term = drive_monitor_pkg::WORD_RST;
        nxt_out_term[drive_monitor_pkg::OUT_BLOWER_BIT] = blower_state;
        nxt_out_term[drive_monitor_pkg::OUT_FAULT_BIT] = fault_contact;
        nxt_out_term[drive_monitor_pkg::OUT_MAIN_BIT] = main_contactor;
        nxt_out_term[drive_monitor_pkg::OUT_OPTION_BIT] = option_contact;
        nxt_out_term[drive_monitor_pkg::OUT_REACHED_BIT] =
            speed_reached_contact;
        nxt_out_term[drive_monitor_pkg::OUT_FLOOR_BIT] = speed_floor_contact;
        nxt_out_term[drive_monitor_pkg::ST2_ACCEL_BIT] = accelerating;
        nxt_out_term[drive_monitor_pkg::ST2_DECEL_BIT] = decelerating;
        nxt_out_term[drive_monitor_pkg::ST2_RETRY_BIT] = retrying;
        nxt_out_term[drive_monitor_pkg::ST2_RUN_BIT] = running_or_braking;
        nxt_out_term[drive_monitor_pkg::ST2_TRIP_BIT] = tripped;
    end

    always_comb begin
        nxt_stat_one = drive_monitor_pkg::WORD_RST;
        nxt_stat_one[drive_monitor_pkg::ST1_RUN_BIT] = running;
        nxt_stat_one[drive_monitor_pkg::ST1_FWD_BIT] = forward;
        nxt_stat_one[drive_monitor_pkg::ST1_ACC2_BIT] = ramp_set_two;
        nxt_stat_one[drive_monitor_pkg::ST1_JOG_BIT] = jog_mode;
        nxt_stat_one[drive_monitor_pkg::ST1_FEEDBACK_BIT] =
            feedback_active;
        nxt_stat_one[drive_monitor_pkg::ST1_DC_BRAKE_BIT] = dc_braking;
        nxt_stat_one[drive_monitor_pkg::ST1_VF2_BIT] = vf_set_two;
        nxt_stat_one[drive_monitor_pkg::ST1_COAST_BIT] = coasting;
        nxt_stat_one[drive_monitor_pkg::ST1_EMERG_BIT] = emergency_off;
    end

    always_comb begin
        nxt_model = drive_monitor_pkg::WORD_RST;
        nxt_model[drive_monitor_pkg::MODEL_CODE_LSB +: 8] =
            MODEL_CODE;
        nxt_model[drive_monitor_pkg::MODEL_PWR_UNITS_BIT] =
            tenth_units_ff;
        nxt_model[drive_monitor_pkg::MODEL_CMD_MODE_LSB +: 2] = command_mode;
        nxt_model[drive_monitor_pkg::MODEL_FREQ_MODE_LSB +: 2] =
            frequency_mode;
    end

    // Snapshots refresh every cycle; nothing on the bus writes them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_term_ff <= drive_monitor_pkg::WORD_RST;
            out_term_ff <= drive_monitor_pkg::WORD_RST;
            stat_one_ff <= drive_monitor_pkg::WORD_RST;
            model_ff <= drive_monitor_pkg::WORD_RST;
            out_volt_ff <= drive_monitor_pkg::WORD_RST;
            in_volt_ff <= drive_monitor_pkg::WORD_RST;
        end else begin
            in_term_ff <= nxt_in_term;
            out_term_ff <= nxt_out_term;
            stat_one_ff <= nxt_stat_one;
            model_ff <= nxt_model;
            out_volt_ff <= out_voltage_pct;
            in_volt_ff <= in_voltage_pct;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt events
    // ---------------------------------------------------------------
    assign ev_level[drive_monitor_pkg::EV_TRIP] = tripped;
    assign ev_level[drive_monitor_pkg::EV_FAULT_CLEAR] = pin_level[9];
    assign ev_level[drive_monitor_pkg::EV_RUN_START] = running;
    assign ev_level[drive_monitor_pkg::EV_EMERG_OFF] = emergency_off;

    genvar e;
    generate
        for (e = 0; e < IRQ_VEC; e++) begin : g_event
            assign ev_pulse[e] = ev_level[e] & ~ev_prev_ff[e];
        end
    endgenerate

    // A new event in the clearing cycle stays set
    assign nxt_irq_status =
        (read_take && hit_irq_status) ? ev_pulse : (irq_status_ff | ev_pulse);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ev_prev_ff <= drive_monitor_pkg::IRQ_RST;
            irq_status_ff <= drive_monitor_pkg::IRQ_RST;
            irq_ff <= 1'b0;
        end else begin
            ev_prev_ff <= ev_level;
            irq_status_ff <= nxt_irq_status;
            irq_ff <= |(nxt_irq_status & irq_mask_ff);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_ff <= drive_monitor_pkg::IRQ_RST;
        end else if (write_take && hit_irq_mask) begin
            irq_mask_ff <= pwdata[IRQ_VEC-1:0];
        end
    end

    // ---------------------------------------------------------------
    // APB address decode
    // ---------------------------------------------------------------
    assign reg_idx = paddr[11:2];
    assign hit_in_term =
        reg_idx == drive_monitor_pkg::IDX_INPUT_TERMINAL_STATUS;
    assign hit_out_term =
        reg_idx == drive_monitor_pkg::IDX_OUTPUT_TERMINAL_AND_STATUS_TWO;
    assign hit_stat_one = reg_idx == drive_monitor_pkg::IDX_DRIVE_STATUS_ONE;
    assign hit_model = reg_idx == drive_monitor_pkg::IDX_MODEL_MODE;
    assign hit_out_volt = reg_idx == drive_monitor_pkg::IDX_OUT_VOLT;
    assign hit_in_volt = reg_idx == drive_monitor_pkg::IDX_IN_VOLT;
    assign hit_in_power = reg_idx == drive_monitor_pkg::IDX_IN_POWER_KW;
    assign hit_out_power = reg_idx == drive_monitor_pkg::IDX_OUT_POWER_KW;
    assign hit_irq_status = reg_idx == drive_monitor_pkg::IDX_IRQ_STATUS;
    assign hit_irq_mask = reg_idx == drive_monitor_pkg::IDX_IRQ_MASK;

    // Side effects act at the answering edge only
    assign access_start = psel && penable && (state_ff == apb_idle);
    assign read_take = access_start && !pwrite && addr_hit;
    assign write_take = access_start && pwrite && addr_hit;

    always_comb begin
        read_word = 32'h0000_0000;
        addr_hit = 1'b1;
        if (hit_in_term) begin
            read_word[15:0] = in_term_ff;
        end else if (hit_out_term) begin
            read_word[15:0] = out_term_ff;
        end else if (hit_stat_one) begin
            read_word[15:0] = stat_one_ff;
        end else if (hit_model) begin
            read_word[15:0] = model_ff;
        end else if (hit_out_volt) begin
            read_word[15:0] = out_volt_ff;
        end else if (hit_in_volt) begin
            read_word[15:0] = in_volt_ff;
        end else if (hit_in_power) begin
            read_word[15:0] = in_power_word;
        end else if (hit_out_power) begin
            read_word[15:0] = out_power_word;
        end else if (hit_irq_status) begin
            read_word[IRQ_VEC-1:0] = irq_status_ff;
        end else if (hit_irq_mask) begin
            read_word[IRQ_VEC-1:0] = irq_mask_ff;
        end else begin
            addr_hit = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // APB answer: one wait state, ready for a single cycle
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            apb_idle: begin
                if (psel && penable) begin
                    nxt_state = apb_answer;
                end
            end
            apb_answer: begin
                nxt_state = apb_idle;
            end
            default: begin
                nxt_state = apb_idle;
            end
        endcase
    end

    // Writes to monitor words are answered but never stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= apb_idle;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            pready_ff <= access_start;
            pslverr_ff <= access_start && !addr_hit;
            if (access_start && !pwrite) begin
                prdata_ff <= read_word;
            end
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
endmodule // drive_status_monitor_words
`default_nettype wire

// [src/pin_sync.sv]
// Two flip-flop synchroniser for a group of pin levels.
// Assumes every bit is a slow level from outside the clock domain.
`default_nettype none
module pin_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    // ---------------------------------------------------------------
    // Per-bit stages
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_ff;
            logic hold_ff;
            // First stage feeds only the second
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_ff <= 1'b0;
                    hold_ff <= 1'b0;
                end else begin
                    meta_ff <= pin_in[g];
                    hold_ff <= meta_ff;
                end
            end
            assign level_out[g] = hold_ff;
        end
    endgenerate
endmodule // pin_sync
`default_nettype wire

// [src/power_scaler.sv]
// Scales a power figure held in 0.01 kW steps into a 16-bit monitor word.
// Assumes the figure comes from logic on the same clock.
`default_nettype none
module power_scaler #(
    parameter bit SIGNED_WORD = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Figure and scale
    input wire logic signed [23:0] centi_kw,
    input wire logic tenth_units,
    output logic [15:0] word_out
);
    logic signed [23:0] scaled;
    logic [15:0] nxt_word;
    logic [15:0] word_ff;
    // Division truncates toward zero; a tenth step loses the hundredths
    assign scaled = tenth_units ? centi_kw / 24'sd10 : centi_kw;
    // Saturate instead of wrapping so a large figure never reads small
    always_comb begin
        nxt_word = scaled[15:0];
        if (SIGNED_WORD) begin
            if (scaled > 24'sh007FFF) begin
                nxt_word = drive_monitor_pkg::SIGNED_MAX;
            end else if (scaled < -24'sh008000) begin
                nxt_word = drive_monitor_pkg::SIGNED_MIN;
            end
        end else begin
            if (scaled < 24'sh000000) begin
                nxt_word = drive_monitor_pkg::WORD_RST;
            end else if (scaled > 24'sh00FFFF) begin
                nxt_word = drive_monitor_pkg::UNSIGNED_MAX;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_ff <= drive_monitor_pkg::WORD_RST;
        end else begin
            word_ff <= nxt_word;
        end
    end
    assign word_out = word_ff;
endmodule // power_scaler
`default_nettype wire
